// ### rtl/tt2_ctrl.sv
// Purpose: Timer two control/status byte, counter, reload pair and capture.
// Assumes: SFR bus is synchronous to the 20 MHz core clock; the external clock is synchronised to it.
// Notes: Read data appears the cycle after a read strobe and then holds.
`timescale 1ns/10ps
module tt2_ctrl (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // Special-function register bus.
    input tt2_pkg::tt2_sfr_req_t sfr_i,
    output logic [7:0] sfr_rdata_o,
    // Interrupt enable from the core and clock selects from clock control.
    input wire logic timer_irq_enable_i,
    input wire logic high_byte_fast_clock_select_i,
    input wire logic low_byte_fast_clock_select_i,
    // External oscillator divided by eight.
    input wire logic ext_clk_div8_i,
    // Interrupt request.
    output logic timer_irq_o
);
    import tt2_pkg::*;

    tt2_ctrl_t ctrl_r;
    tt2_ctrl_t ctrl_nxt;
    logic [15:0] cnt_r;
    logic [15:0] cnt_nxt;
    logic [15:0] rld_r;
    logic [15:0] rld_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic irq_r;
    logic irq_nxt;
    logic tick12;
    logic ext_tick;
    logic ext_fall;
    logic tick_l;
    logic tick_h;
    logic hf_set;
    logic lf_set;
    logic ctrl_wr;
    logic ctrl_bit_wr;
    logic capture;

    // Fast select takes the core clock; otherwise the external select chooses.
    function automatic logic sel_tick(input logic fast, input logic xclk,
                                      input logic t12, input logic tx);
        sel_tick = fast ? 1'b1 : (xclk ? tx : t12);
    endfunction

    tt2_tick_gen u_tick (
        .mclk_i(mclk_i),
        .rst_b_i(rst_b_i),
        .ext_clk_div8_i(ext_clk_div8_i),
        .tick12_o(tick12),
        .ext_tick_o(ext_tick),
        .ext_fall_o(ext_fall)
    );

    // Per-byte tick selection and bus decode.
    always_comb begin
        tick_l = sel_tick(low_byte_fast_clock_select_i, ctrl_r.xclk, tick12, ext_tick);
        tick_h = sel_tick(high_byte_fast_clock_select_i, ctrl_r.xclk, tick12, ext_tick);
        ctrl_wr = sfr_i.wr && (sfr_i.addr == TT2_ADDR_CTRL);
        ctrl_bit_wr = sfr_i.bit_wr && (sfr_i.bit_addr[7:3] == TT2_ADDR_CTRL[7:3]);
        capture = ctrl_r.cen && ext_fall;
    end

    // Counter, reload and flag events; software byte writes win over counting.
    always_comb begin
        cnt_nxt = cnt_r;
        rld_nxt = rld_r;
        hf_set = 1'b0;
        lf_set = 1'b0;
        if (!ctrl_r.split) begin
            if (ctrl_r.run && tick_l) begin
                if (cnt_r == TT2_WORD_MAX) begin
                    cnt_nxt = rld_r;
                    hf_set = 1'b1;
                    lf_set = 1'b1;
                end else begin
                    cnt_nxt = 16'(cnt_r + 16'h0001);
                    lf_set = (cnt_r[7:0] == TT2_BYTE_MAX);
                end
            end
        end else begin
            // The low byte ignores run control in split mode.
            if (tick_l) begin
                if (cnt_r[7:0] == TT2_BYTE_MAX) begin
                    cnt_nxt[7:0] = rld_r[7:0];
                    lf_set = 1'b1;
                end else begin
                    cnt_nxt[7:0] = 8'(cnt_r[7:0] + 8'h01);
                end
            end
            if (ctrl_r.run && tick_h) begin
                if (cnt_r[15:8] == TT2_BYTE_MAX) begin
                    cnt_nxt[15:8] = rld_r[15:8];
                    hf_set = 1'b1;
                end else begin
                    cnt_nxt[15:8] = 8'(cnt_r[15:8] + 8'h01);
                end
            end
        end
        if (sfr_i.wr && sfr_i.addr == TT2_ADDR_CNT_L) begin
            cnt_nxt[7:0] = sfr_i.wdata;
        end
        if (sfr_i.wr && sfr_i.addr == TT2_ADDR_CNT_H) begin
            cnt_nxt[15:8] = sfr_i.wdata;
        end
        if (sfr_i.wr && sfr_i.addr == TT2_ADDR_RLD_L) begin
            rld_nxt[7:0] = sfr_i.wdata;
        end
        if (sfr_i.wr && sfr_i.addr == TT2_ADDR_RLD_H) begin
            rld_nxt[15:8] = sfr_i.wdata;
        end
        // A capture overrides a same-cycle reload write so no measurement is lost.
        if (capture) begin
            rld_nxt = cnt_r;
            hf_set = 1'b1;
        end
    end

    // Control byte: byte and bit writes, then hardware sets win over clears.
    always_comb begin
        ctrl_nxt = ctrl_r;
        if (ctrl_wr) begin
            ctrl_nxt = sfr_i.wdata;
        end
        if (ctrl_bit_wr) begin
            ctrl_nxt[sfr_i.bit_addr[2:0]] = sfr_i.bit_val;
        end
        ctrl_nxt[TT2_BIT_UNUSED] = 1'b0;
        ctrl_nxt[TT2_BIT_HF] = ctrl_nxt[TT2_BIT_HF] | hf_set;
        ctrl_nxt[TT2_BIT_LF] = ctrl_nxt[TT2_BIT_LF] | lf_set;
        irq_nxt = timer_irq_enable_i & (ctrl_nxt.hf | (ctrl_nxt.lf & ctrl_nxt.len));
    end

    // Read mux; unmapped addresses read as zero.
    always_comb begin
        rdata_nxt = rdata_r;
        if (sfr_i.rd) begin
            case (sfr_i.addr)
                TT2_ADDR_CTRL: rdata_nxt = ctrl_r;
                TT2_ADDR_RLD_L: rdata_nxt = rld_r[7:0];
                TT2_ADDR_RLD_H: rdata_nxt = rld_r[15:8];
                TT2_ADDR_CNT_L: rdata_nxt = cnt_r[7:0];
                TT2_ADDR_CNT_H: rdata_nxt = cnt_r[15:8];
                default: rdata_nxt = 8'h00;
            endcase
        end
    end

    // All state registers; reset clears everything.
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ctrl_r <= TT2_CTRL_RESET;
            cnt_r <= TT2_WORD_RESET;
            rld_r <= TT2_WORD_RESET;
            rdata_r <= 8'h00;
            irq_r <= 1'b0;
        end else begin
            ctrl_r <= ctrl_nxt;
            cnt_r <= cnt_nxt;
            rld_r <= rld_nxt;
            rdata_r <= rdata_nxt;
            irq_r <= irq_nxt;
        end
    end

    assign sfr_rdata_o = rdata_r;
    assign timer_irq_o = irq_r;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    logic no_wr;
    assign no_wr = !sfr_i.wr && !sfr_i.bit_wr;

    property p_wrap16;
        !ctrl_r.split && ctrl_r.run && tick_l && cnt_r == 16'hFFFF && no_wr && !capture
            |=> ctrl_r.hf && ctrl_r.lf && cnt_r == $past(rld_r);
    endproperty
    a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

    property p_no_hw_clear;
        no_wr |=> (ctrl_r.hf || !$past(ctrl_r.hf)) && (ctrl_r.lf || !$past(ctrl_r.lf));
    endproperty
    a_no_hw_clear: assert property (p_no_hw_clear) else $error("flag cleared by hardware");

    property p_irq_high;
        timer_irq_enable_i && ctrl_r.hf && no_wr |=> timer_irq_o;
    endproperty
    a_irq_high: assert property (p_irq_high) else $error("missing high interrupt");

    property p_low_wrap;
        ctrl_r.split && tick_l && cnt_r[7:0] == 8'hFF && no_wr |=> ctrl_r.lf;
    endproperty
    a_low_wrap: assert property (p_low_wrap) else $error("low flag not set");

    property p_irq_low;
        timer_irq_enable_i && ctrl_r.lf && ctrl_r.len && no_wr |=> timer_irq_o;
    endproperty
    a_irq_low: assert property (p_irq_low) else $error("missing low interrupt");

    property p_irq_low_gate;
        timer_irq_enable_i && ctrl_r.lf && !ctrl_r.len && !ctrl_r.hf && no_wr
            && !hf_set |=> !timer_irq_o;
    endproperty
    a_irq_low_gate: assert property (p_irq_low_gate) else $error("low irq not gated");

    property p_hold;
        !ctrl_r.run && !ctrl_r.split && no_wr |=> $stable(cnt_r);
    endproperty
    a_hold: assert property (p_hold) else $error("count moved while stopped");

    property p_split_low_runs;
        ctrl_r.split && !ctrl_r.run && tick_l && cnt_r[7:0] != 8'hFF && no_wr
            |=> cnt_r[7:0] == 8'($past(cnt_r[7:0]) + 8'h01) && $stable(cnt_r[15:8]);
    endproperty
    a_split_low_runs: assert property (p_split_low_runs) else $error("split low stalled");

    property p_unused_zero;
        sfr_i.rd && sfr_i.addr == TT2_ADDR_CTRL |=> !sfr_rdata_o[1];
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused bit read one");

    property p_capture;
        ctrl_r.cen && ext_fall |=> rld_r == $past(cnt_r) && ctrl_r.hf;
    endproperty
    a_capture: assert property (p_capture) else $error("capture missed");

    c_wrap16: cover property (!ctrl_r.split && hf_set);
    c_split_both: cover property (ctrl_r.split && hf_set && lf_set);
    c_capture: cover property (capture);
endmodule // tt2_ctrl

// ### rtl/tt2_pkg.sv
// Purpose: Shared constants and carriers for the timer two control block.
// Assumes: One core clock; the special-function bus is synchronous to it.
// Notes: Byte timers, reload pair and control byte all sit on one SFR bus.
// Behaviour
// - High overflow flag sets when upper byte, or full 16-bit count, wraps.
// - Hardware never clears either overflow flag; software writes zero to clear.
// - With timer interrupt enabled, a set high overflow flag requests an interrupt.
// - Low overflow flag sets whenever the low byte wraps, in either mode.
// - With low interrupt enable and timer interrupt, low overflows also request interrupts.
// - Capture enable field turns capture mode on when one, off when zero.
// - Split clear gives one 16-bit auto-reload timer; set gives two 8-bit ones.
// - Outside split mode the counter advances only while run control is one; otherwise the count holds.
// - In split mode run control gates only the upper byte timer.
// - Control bit one reads zero and ignores writes.
// - Without fast select, external clock select picks core clock/12 or external/8.
// - External divided-by-8 source is synchronised to the core clock before use.
// - In split mode one external select serves both bytes; fast selects override.
// - Control register at SFR 0xC8, bit-addressable, resets to all zeros.
// - On 16-bit overflow the reload pair loads into the counter, setting high flag.
// - In capture mode each external falling edge copies count to reload, sets flag.
// - In split mode each byte's fast-clock select one picks core clock directly; outside split mode only the low-byte select does.
package tt2_pkg;
    localparam logic [7:0] TT2_ADDR_CTRL = 8'hC8;
    localparam logic [7:0] TT2_ADDR_RLD_L = 8'hCA;
    localparam logic [7:0] TT2_ADDR_RLD_H = 8'hCB;
    localparam logic [7:0] TT2_ADDR_CNT_L = 8'hCC;
    localparam logic [7:0] TT2_ADDR_CNT_H = 8'hCD;
    localparam logic [7:0] TT2_CTRL_RESET = 8'h00;
    localparam logic [15:0] TT2_WORD_RESET = 16'h0000;
    localparam logic [15:0] TT2_WORD_MAX = 16'hFFFF;
    localparam logic [7:0] TT2_BYTE_MAX = 8'hFF;
    localparam int TT2_BIT_UNUSED = 1;
    localparam int TT2_BIT_HF = 7;
    localparam int TT2_BIT_LF = 6;
    localparam logic [3:0] TT2_PRESCALE_LAST = 4'hB;

    // Control byte, most significant field first.
    typedef struct packed {
        logic hf;
        logic lf;
        logic len;
        logic cen;
        logic split;
        logic run;
        logic unused;
        logic xclk;
    } tt2_ctrl_t;

    // One SFR bus cycle: byte write, byte read and single-bit write.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic bit_wr;
        logic [7:0] bit_addr;
        logic bit_val;
    } tt2_sfr_req_t;
endpackage

// ### rtl/tt2_tick_gen.sv
// Purpose: Count-source ticks: core clock/12 and synchronised external/8 edges.
// Assumes: The external divided clock is far slower than the core clock.
// Notes: Edges are taken from the second and third synchroniser stages only.
`timescale 1ns/10ps
module tt2_tick_gen (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_b_i,
    // External oscillator divided by eight.
    input wire logic ext_clk_div8_i,
    // Single-cycle tick pulses.
    output logic tick12_o,
    output logic ext_tick_o,
    output logic ext_fall_o
);
    import tt2_pkg::*;

    logic [3:0] pre_r;
    logic [3:0] pre_nxt;
    logic [2:0] sync_r;
    logic [2:0] sync_nxt;

    // Prescaler wraps every twelve cycles; the synchroniser shifts in the input.
    always_comb begin
        pre_nxt = (pre_r == TT2_PRESCALE_LAST) ? 4'h0 : 4'(pre_r + 4'h1);
        sync_nxt = {sync_r[1:0], ext_clk_div8_i};
    end

    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pre_r <= 4'h0;
            sync_r <= 3'h0;
        end else begin
            pre_r <= pre_nxt;
            sync_r <= sync_nxt;
        end
    end

    // Stage zero feeds stage one only, so metastability never reaches an edge detector.
    assign tick12_o = (pre_r == TT2_PRESCALE_LAST);
    assign ext_tick_o = sync_r[1] & ~sync_r[2];
    assign ext_fall_o = ~sync_r[1] & sync_r[2];

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);

    property p_tick12_period;
        tick12_o |=> !tick12_o [*8] ##1 !tick12_o [*3] ##1 tick12_o;
    endproperty
    a_tick12_period: assert property (p_tick12_period) else $error("prescale period wrong");

    property p_ext_sync;
        $rose(ext_clk_div8_i) ##1 ext_clk_div8_i |-> ##1 ext_tick_o ##1 !ext_tick_o;
    endproperty
    a_ext_sync: assert property (p_ext_sync) else $error("external edge not synced");

    c_ext_fall: cover property (ext_fall_o);
endmodule // tt2_tick_gen

// ### tb/tt2_testbench.sv
// Purpose: Self-checking bench for the timer two control block.
// Assumes: Design asserts sit in the design files; the bench drives every port.
// Notes: Counts near tick boundaries are checked within a one-tick window.
`timescale 1ns/10ps
module testbench;
    import tt2_pkg::*;
    typedef struct packed {logic [7:0] addr; logic [7:0] wd; logic [7:0] exp;} tt2_row_t;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    tt2_sfr_req_t sfr = '0;
    logic [7:0] rdata;
    logic irq_en = 1'b0;
    logic fast_h = 1'b0;
    logic fast_l = 1'b0;
    logic ext = 1'b0;
    logic irq;
    logic [7:0] v;
    logic [7:0] a;
    int errors = 0;
    int comparisons = 0;
    tt2_row_t rows [7] = '{'{8'hC8, 8'hF2, 8'hF0}, '{8'hC8, 8'h00, 8'h00},
        '{8'hCA, 8'h5A, 8'h5A}, '{8'hCB, 8'hA5, 8'hA5}, '{8'hCC, 8'h3C, 8'h3C},
        '{8'hCD, 8'hC3, 8'hC3}, '{8'hC9, 8'h77, 8'h00}};
    logic [7:0] addrs [6] = '{8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD};

    // Core clock at 20 MHz.
    always #25 mclk = ~mclk;

    tt2_ctrl dut (.mclk_i(mclk), .rst_b_i(rst_b), .sfr_i(sfr), .sfr_rdata_o(rdata),
        .timer_irq_enable_i(irq_en), .high_byte_fast_clock_select_i(fast_h),
        .low_byte_fast_clock_select_i(fast_l), .ext_clk_div8_i(ext), .timer_irq_o(irq));

    // Strobes rise just after an edge and drop just after the taking edge.
    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        @(posedge mclk) #2;
        sfr.wr = 1'b1; sfr.addr = ad; sfr.wdata = d;
        @(posedge mclk) #2;
        sfr.wr = 1'b0;
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] d);
        @(posedge mclk) #2;
        sfr.rd = 1'b1; sfr.addr = ad;
        @(posedge mclk) #2;
        sfr.rd = 1'b0;
        d = rdata;
    endtask
    task automatic bw(input logic [7:0] ba, input logic b);
        @(posedge mclk) #2;
        sfr.bit_wr = 1'b1; sfr.bit_addr = ba; sfr.bit_val = b;
        @(posedge mclk) #2;
        sfr.bit_wr = 1'b0;
    endtask
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            errors++;
            $display("FAIL %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // External source: eight cycles high, then nine low before the next pulse.
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge mclk) #2 ext = 1'b1;
            repeat (8) @(posedge mclk);
            #2 ext = 1'b0;
            repeat (8) @(posedge mclk);
        end
    endtask
    task automatic test_done();
        $display("Comparisons %0d, errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Watchdog sized well above the few hundred cycles the tests take.
    initial begin
        #(50 * 20000);
        errors++;
        test_done();
    end

    initial begin
        repeat (3) @(posedge mclk);
        #2 rst_b = 1'b1;
        // Reset values, unmapped place included.
        foreach (addrs[i]) begin
            rd(addrs[i], v);
            check("reset value", v, 8'h00);
        end
        // Write then read back; bit one and unmapped writes have no effect.
        foreach (rows[i]) begin
            wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr, v);
            check("readback", v, rows[i].exp);
        end
        // Sixteen-bit wrap on the core clock loads the reload pair.
        fast_l = 1'b1;
        wr(8'hCA, 8'h34);
        wr(8'hCB, 8'h12);
        wr(8'hCC, 8'hFF);
        wr(8'hCD, 8'hFF);
        wr(8'hC8, 8'h04);
        bw(8'hCA, 1'b0);
        rd(8'hC8, v);
        check("wrap flags", v, 8'hC0);
        rd(8'hCD, v);
        check("reload high", v, 8'h12);
        check("irq masked", {7'h00, irq}, 8'h00);
        irq_en = 1'b1;
        repeat (2) @(posedge mclk);
        #2 check("irq high flag", {7'h00, irq}, 8'h01);
        bw(8'hCF, 1'b0);
        repeat (2) @(posedge mclk);
        #2 check("low flag alone", {7'h00, irq}, 8'h00);
        bw(8'hCD, 1'b1);
        repeat (2) @(posedge mclk);
        #2 check("low flag enabled", {7'h00, irq}, 8'h01);
        rd(8'hC8, v);
        check("low flag kept", v, 8'h60);
        bw(8'hCE, 1'b0);
        repeat (2) @(posedge mclk);
        #2 check("flags cleared", {7'h00, irq}, 8'h00);
        irq_en = 1'b0;
        wr(8'hC8, 8'h00);
        // Stopped counter holds its value.
        rd(8'hCC, a);
        repeat (30) @(posedge mclk);
        rd(8'hCC, v);
        check("count held", v, a);
        // Split mode: low byte runs with run control clear, high byte holds.
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h08);
        repeat (10) @(posedge mclk);
        wr(8'hC8, 8'h00);
        rd(8'hCD, v);
        check("split high held", v, 8'h00);
        rd(8'hCC, v);
        check("split low runs", v, 8'h0C);
        // Core clock divided by twelve.
        fast_l = 1'b0;
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h04);
        repeat (120) @(posedge mclk);
        bw(8'hCA, 1'b0);
        rd(8'hCC, v);
        check("div12 count", {7'h00, v >= 8'h0A && v <= 8'h0B}, 8'h01);
        // External source divided by eight, counted once per period.
        wr(8'hCC, 8'h00);
        wr(8'hC8, 8'h05);
        ext_pulses(5);
        bw(8'hCA, 1'b0);
        rd(8'hCC, v);
        check("ext count", v, 8'h05);
        rd(8'hC8, v);
        check("no capture", v, 8'h01);
        // Split with external select: high byte forced to core clock, low byte on external.
        fast_h = 1'b1;
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hC8, 8'h0D);
        ext_pulses(3);
        wr(8'hC8, 8'h00);
        rd(8'hCC, v);
        check("split ext low", v, 8'h03);
        rd(8'hCD, v);
        check("split fast high", v, 8'h35);
        // Capture on a falling external edge.
        fast_l = 1'b1;
        wr(8'hC8, 8'h00);
        wr(8'hCC, 8'h00);
        wr(8'hCD, 8'h00);
        wr(8'hCA, 8'h00);
        ext = 1'b1;
        wr(8'hC8, 8'h14);
        repeat (20) @(posedge mclk);
        #2 ext = 1'b0;
        repeat (6) @(posedge mclk);
        bw(8'hCA, 1'b0);
        rd(8'hC8, v);
        check("capture flag", v, 8'h90);
        rd(8'hCA, v);
        check("captured low", v, 8'h16);
        // Reset in mid-run clears everything, a pending interrupt included.
        irq_en = 1'b1;
        wr(8'hC8, 8'h84);
        check("irq before reset", {7'h00, irq}, 8'h01);
        @(posedge mclk) #2 rst_b = 1'b0;
        repeat (2) @(posedge mclk);
        #2 check("irq in reset", {7'h00, irq}, 8'h00);
        check("rdata in reset", rdata, 8'h00);
        rst_b = 1'b1;
        rd(8'hC8, v);
        check("ctrl after reset", v, 8'h00);
        check("irq after reset", {7'h00, irq}, 8'h00);
        rd(8'hCC, v);
        check("count after reset", v, 8'h00);
        test_done();
    end
endmodule // testbench
